/* hw/tbpo_defs.svh */
// register map, field positions, reset values and masks of the timer output block
`ifndef TBPO_DEFS_SVH
`define TBPO_DEFS_SVH
`define TBPO_ADDR_MODE 8'hdc
`define TBPO_ADDR_COUNT 8'hdd
`define TBPO_ADDR_RELOAD 8'hde
`define TBPO_ADDR_IRQ 8'hdf
`define TBPO_RATE_LSB 4
`define TBPO_RATE_MSB 6
`define TBPO_BIT_IEN 0
`define TBPO_BIT_IRQ 1
`define TBPO_BIT_PWM 0
`define TBPO_BIT_TOG 1
`define TBPO_RST_BYTE 8'h00
`define TBPO_MASK_256 8'hff
`define TBPO_MASK_64 8'h3f
`define TBPO_MASK_32 8'h1f
`define TBPO_MASK_16 8'h0f
`endif

/* hw/tbpo_pkg.sv */
// types shared by the timer output block
package tbpo_pkg;
    // mode register, bit 7 down to bit 0
    typedef struct packed {
        logic run;
        logic [2:0] rate;
        logic clk_sel;
        logic aload;
        logic tog;
        logic pwm;
    } tbpo_mode_s;

    // one register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tbpo_req_s;

    // shared port pin
    typedef struct packed {
        logic value;
        logic takeover;
    } tbpo_pin_s;

    // tick generator state
    typedef struct packed {
        logic [1:0] sync;
        logic last;
        logic [7:0] presc;
        logic tick;
    } tbpo_tick_s;

    // timer state
    typedef struct packed {
        tbpo_mode_s mode;
        logic [7:0] count;
        logic [7:0] reload;
        logic ien;
        logic flag;
        logic tog;
        tbpo_pin_s pin;
        logic [7:0] rdata;
        logic irq_out;
    } tbpo_state_s;
endpackage : tbpo_pkg

/* hw/tbpo_tick_gen.sv */
// count tick source: rate prescaler or falling edges of the event pin
`timescale 1ns/1ps
`default_nettype none
`include "tbpo_defs.svh"
module tbpo_tick_gen
    import tbpo_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic run,
    input wire logic ext_sel,
    input wire logic [2:0] rate,
    input wire logic event_pin,
    output logic tick
);
    tbpo_tick_s st;
    tbpo_tick_s next_st;
    logic [7:0] div_mask;

    // rate 000 divides by 256, 111 by 2
    assign div_mask = `TBPO_MASK_256 >> rate;

    // sync[1] is the only reader of sync[0]; edge logic looks at sync[1] and last
    always_comb begin
        next_st = st;
        if (clk_en) begin
            next_st.sync = {st.sync[0], event_pin};
            next_st.last = st.sync[1];
            next_st.tick = 1'b0;
            if (!run) begin
                next_st.presc = 8'h00;
            end else if (ext_sel) begin
                // external events ignore the rate field entirely
                next_st.presc = 8'h00;
                next_st.tick = st.last & ~st.sync[1];
            end else begin
                next_st.presc = 8'(st.presc + 8'h01);
                next_st.tick = (st.presc & div_mask) == div_mask;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule : tbpo_tick_gen
`default_nettype wire

/* hw/tbpo_timer.sv */
// 8-bit up timer with buzzer toggle and pwm output on one shared pin
// Behaviour
// - buzzer enabled: pin inverts on every overflow, half the overflow rate.
// - buzzer enable hands the shared pin to the timer, gpio off.
// - run bit low stops counting and freezes buzzer and pwm outputs.
// - rate select sits in bits 4 to 6 of the mode register.
// - pwm modulus on the rate source from aload/toggle bits: 256, 64, 32, 16; event source always 256; low bits used.
// - pwm pin high while count below reference, low otherwise.
// - counter wraps through zero each pwm cycle, output high again unless reference is zero.
// - software write of the count changes the duty at once.
// - raising reference after output fell drives it high again.
// - reload register is write-only; software keeps a shadow copy.
// - pwm mode still raises the interrupt flag on each overflow.
// - pwm enable routes waveform to the shared pin, gpio off.
// - external event source makes the rate field irrelevant.
// - pwm mode reloads automatically; aload and toggle bits pick the boundary.
// - outside pwm mode with auto-reload on, reload value is copied to count on overflow.
// - on overflow the timer keeps counting and raises a request.
`timescale 1ns/1ps
`default_nettype none
`include "tbpo_defs.svh"
module tbpo_timer
    import tbpo_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire tbpo_req_s bus_req,
    output logic [7:0] rdata,
    input wire logic event_pin,
    output tbpo_pin_s pin,
    output logic irq_out
);
    tbpo_state_s st;
    tbpo_state_s next_st;
    logic tick;
    logic [7:0] cnt_mask;
    logic [7:0] cnt_m;
    logic [7:0] ref_m;
    logic ovf;
    logic wr_mode;
    logic wr_count;
    logic wr_reload;
    logic wr_irq;
    logic pwm_cmp;

    // every check below runs on the system clock and sleeps through reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // tick source; prescaler restarts whenever the timer is stopped
    tbpo_tick_gen u_tick (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .run(st.mode.run),
        .ext_sel(st.mode.clk_sel),
        .rate(st.mode.rate),
        .event_pin(event_pin),
        .tick(tick)
    );

    // register write decode
    assign wr_mode = bus_req.wr && bus_req.addr == `TBPO_ADDR_MODE;
    assign wr_count = bus_req.wr && bus_req.addr == `TBPO_ADDR_COUNT;
    assign wr_reload = bus_req.wr && bus_req.addr == `TBPO_ADDR_RELOAD;
    assign wr_irq = bus_req.wr && bus_req.addr == `TBPO_ADDR_IRQ;

    // overflow boundary; event counting always uses the full 256 range
    always_comb begin
        cnt_mask = `TBPO_MASK_256;
        if (st.mode.pwm && !st.mode.clk_sel) begin
            case ({st.mode.aload, st.mode.tog})
                2'b00: cnt_mask = `TBPO_MASK_256;
                2'b01: cnt_mask = `TBPO_MASK_64;
                2'b10: cnt_mask = `TBPO_MASK_32;
                2'b11: cnt_mask = `TBPO_MASK_16;
                default: cnt_mask = `TBPO_MASK_256;
            endcase
        end
    end

    // only the low-order bits take part in pwm compare and wrap
    assign cnt_m = st.count & cnt_mask;
    assign ref_m = st.reload & cnt_mask;
    assign ovf = st.mode.run && tick && cnt_m == cnt_mask;

    // continuous compare against the live reference, so a late raise of the
    // reference pulls the pin high again on the second edge after the write
    assign pwm_cmp = cnt_m < ref_m;

    // next state of the whole block
    always_comb begin
        next_st = st;
        next_st.rdata = 8'h00;
        if (clk_en) begin
            // mode register
            if (wr_mode) begin
                next_st.mode = tbpo_mode_s'(bus_req.wdata);
            end
            // reference is not double buffered: writes take effect at once
            if (wr_reload) begin
                next_st.reload = bus_req.wdata;
            end
            // counter: software write beats a tick in the same cycle
            if (wr_count) begin
                next_st.count = bus_req.wdata;
            end else if (ovf) begin
                if (st.mode.pwm) begin
                    next_st.count = 8'h00;
                end else if (st.mode.aload) begin
                    next_st.count = st.reload;
                end else begin
                    next_st.count = 8'h00;
                end
            end else if (st.mode.run && tick) begin
                next_st.count = 8'(st.count + 8'h01);
            end
            // buzzer toggles only outside pwm mode
            if (ovf && st.mode.tog && !st.mode.pwm) begin
                next_st.tog = ~st.tog;
            end
            // pin level follows the selected function while running
            if (st.mode.run) begin
                if (st.mode.pwm) begin
                    next_st.pin.value = pwm_cmp;
                end else begin
                    next_st.pin.value = next_st.tog;
                end
            end
            next_st.pin.takeover = next_st.mode.pwm | next_st.mode.tog;
            // interrupt control; overflow set wins over a software clear
            if (wr_irq) begin
                next_st.ien = bus_req.wdata[`TBPO_BIT_IEN];
                next_st.flag = bus_req.wdata[`TBPO_BIT_IRQ];
            end
            if (ovf) begin
                next_st.flag = 1'b1;
            end
            next_st.irq_out = next_st.flag & next_st.ien;
            // read data stands in the cycle after the strobe only
            if (bus_req.rd) begin
                case (bus_req.addr)
                    `TBPO_ADDR_MODE: next_st.rdata = st.mode;
                    `TBPO_ADDR_COUNT: next_st.rdata = st.count;
                    `TBPO_ADDR_RELOAD: next_st.rdata = 8'h00;
                    `TBPO_ADDR_IRQ: begin
                        next_st.rdata[`TBPO_BIT_IEN] = st.ien;
                        next_st.rdata[`TBPO_BIT_IRQ] = st.flag;
                    end
                    default: next_st.rdata = 8'h00;
                endcase
            end
        end else begin
            // frozen: read data still drops after its one cycle
            next_st.rdata = 8'h00;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flops
    assign rdata = st.rdata;
    assign pin = st.pin;
    assign irq_out = st.irq_out;

    // checks

    AST_TOGGLE_ON_OVF: assert property (
        ovf && clk_en && st.mode.tog && !st.mode.pwm |=> st.tog != $past(st.tog)
    ) else $error("buzzer did not toggle on overflow");

    AST_PIN_OWNER: assert property (
        clk_en && !wr_mode |=> pin.takeover == ($past(st.mode.pwm) | $past(st.mode.tog))
    ) else $error("pin ownership does not follow the enables");

    AST_HALT: assert property (
        clk_en && !st.mode.run && !wr_count |=> $stable(st.count) && $stable(pin.value) && $stable(st.tog)
    ) else $error("stopped timer changed count or output");

    AST_RATE_FIELD: assert property (
        clk_en && wr_mode |=> st.mode.rate == $past(bus_req.wdata[`TBPO_RATE_MSB:`TBPO_RATE_LSB])
    ) else $error("rate field not taken from bits 6..4");

    AST_PWM_WRAP: assert property (
        ovf && clk_en && st.mode.pwm && !wr_count |=> st.count == 8'h00
    ) else $error("pwm counter did not wrap to zero");

    AST_PWM_COMPARE: assert property (
        clk_en && st.mode.run && st.mode.pwm |=> pin.value == ($past(cnt_m) < $past(ref_m))
    ) else $error("pwm level does not match compare");

    AST_PWM_NEW_CYCLE: assert property (
        ovf && clk_en && st.mode.pwm && ref_m != 8'h00 && !wr_count && !bus_req.wr
        ##1 clk_en && st.mode.run && st.mode.pwm |=> pin.value
    ) else $error("pwm cycle did not start high");

    AST_OVF_FLAG: assert property (
        ovf && clk_en |=> st.flag
    ) else $error("overflow did not set the request flag");

    AST_AUTO_RELOAD: assert property (
        ovf && clk_en && !st.mode.pwm && st.mode.aload && !wr_count && !wr_reload |=> st.count == $past(st.reload)
    ) else $error("reload value not copied on overflow");

    AST_WRITE_ONLY: assert property (
        clk_en && bus_req.rd && bus_req.addr == `TBPO_ADDR_RELOAD |=> rdata == 8'h00
    ) else $error("reload register readable");

    AST_IRQ_GATE: assert property (
        clk_en |=> irq_out == (st.flag & st.ien)
    ) else $error("interrupt output not gated by enable");

    AST_FLAG_STICKY: assert property (
        clk_en && st.flag && !wr_irq |=> st.flag
    ) else $error("request flag dropped without a software clear");

    AST_FLAG_CLEAR: assert property (
        clk_en && wr_irq && !ovf && !bus_req.wdata[`TBPO_BIT_IRQ] |=> !st.flag
    ) else $error("software clear of the request flag lost");

    // register side
    AST_MODE_READBACK: assert property (
        clk_en && bus_req.rd && bus_req.addr == `TBPO_ADDR_MODE |=> rdata == $past(st.mode)
    ) else $error("mode register read back wrong");

    AST_COUNT_WRITE: assert property (
        clk_en && wr_count |=> st.count == $past(bus_req.wdata)
    ) else $error("count write not taken at once");

    // duty follows software writes within the running cycle, no waiting for the wrap
    AST_DUTY_AT_ONCE: assert property (
        clk_en && wr_count && !wr_mode && st.mode.run && st.mode.pwm ##1 clk_en
        |=> pin.value == (($past(bus_req.wdata, 2) & $past(cnt_mask)) < $past(ref_m))
    ) else $error("count write did not change the duty at once");

    AST_REF_RAISE: assert property (
        clk_en && st.mode.run && st.mode.pwm && !pin.value && !tick && wr_reload && !wr_count && !wr_mode
        && cnt_m < (bus_req.wdata & cnt_mask) ##1 clk_en |=> pin.value
    ) else $error("raised reference did not pull the pin high again");

    // pwm boundaries, each written from its own bit pattern rather than from cnt_mask
    AST_WRAP_256: assert property (
        clk_en && tick && st.mode.run && st.mode.pwm && !st.mode.clk_sel && !st.mode.aload && !st.mode.tog
        && st.count == 8'hff && !wr_count |=> st.count == 8'h00
    ) else $error("pwm did not wrap after 256 counts");

    AST_WRAP_64: assert property (
        clk_en && tick && st.mode.run && st.mode.pwm && !st.mode.clk_sel && !st.mode.aload && st.mode.tog
        && st.count[5:0] == 6'h3f && !wr_count |=> st.count == 8'h00
    ) else $error("pwm did not wrap after 64 counts");

    AST_WRAP_32: assert property (
        clk_en && tick && st.mode.run && st.mode.pwm && !st.mode.clk_sel && st.mode.aload && !st.mode.tog
        && st.count[4:0] == 5'h1f && !wr_count |=> st.count == 8'h00
    ) else $error("pwm did not wrap after 32 counts");

    AST_WRAP_16: assert property (
        clk_en && tick && st.mode.run && st.mode.pwm && !st.mode.clk_sel && st.mode.aload && st.mode.tog
        && st.count[3:0] == 4'hf && !wr_count |=> st.count == 8'h00
    ) else $error("pwm did not wrap after 16 counts");

    AST_KEEP_COUNTING: assert property (
        clk_en && st.mode.run && tick && !ovf && !wr_count |=> st.count == 8'($past(st.count) + 8'h01)
    ) else $error("counter did not step on a tick");

    // pin ownership
    AST_PIN_TO_PWM: assert property (
        clk_en && wr_mode && bus_req.wdata[`TBPO_BIT_PWM] |=> pin.takeover
    ) else $error("pwm enable did not take the pin");

    AST_PIN_TO_BUZZER: assert property (
        clk_en && wr_mode && bus_req.wdata[`TBPO_BIT_TOG] |=> pin.takeover
    ) else $error("buzzer enable did not take the pin");

    AST_PIN_RELEASE: assert property (
        clk_en && wr_mode && !bus_req.wdata[`TBPO_BIT_TOG] && !bus_req.wdata[`TBPO_BIT_PWM] |=> !pin.takeover
    ) else $error("pin not handed back to gpio");

    // buzzer
    AST_BUZZER_PIN: assert property (
        clk_en && st.mode.run && !st.mode.pwm |=> pin.value == st.tog
    ) else $error("pin does not follow the buzzer toggle");

    AST_NO_TOGGLE_IN_PWM: assert property (
        clk_en && st.mode.pwm |=> st.tog == $past(st.tog)
    ) else $error("buzzer toggled in pwm mode");

    // halted timer
    AST_STOP_NO_TICK: assert property (
        clk_en && !st.mode.run |=> !tick
    ) else $error("stopped timer still ticks");

    AST_STOP_NO_FLAG: assert property (
        clk_en && !st.mode.run && !wr_irq |=> st.flag == $past(st.flag)
    ) else $error("stopped timer raised a request");
endmodule : tbpo_timer
`default_nettype wire

/* tb/tbpo_load.sv */
// external load on the shared timer pin: measures level widths in clock cycles
`timescale 1ns/1ps
`default_nettype none
module tbpo_load
    import tbpo_pkg::*;
(
    input wire logic clk_sys,
    input wire tbpo_pin_s pin,
    output int hi_w,
    output int lo_w,
    output int rises
);
    logic last = 1'b0;
    int cur = 0;
    logic level;
    // pull-down on the load: a pin left to gpio reads low, never a stale timer level
    assign level = pin.takeover ? pin.value : 1'b0;
    // a width is recorded only when the level ends, so a partial first level is harmless
    always @(posedge clk_sys) begin
        if (level !== last) begin
            if (last) hi_w <= cur;
            else lo_w <= cur;
            if (level) rises <= rises + 1;
            cur <= 1;
            last <= level;
        end else begin
            cur <= cur + 1;
        end
    end
endmodule : tbpo_load
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the timer buzzer and pwm output block
`timescale 1ns/1ps
`default_nettype none
`include "tbpo_defs.svh"
module testbench
    import tbpo_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic event_pin = 1'b1;
    tbpo_req_s bus_req = '0;
    logic [7:0] rdata;
    tbpo_pin_s pin;
    logic irq_out;
    int hi_w, lo_w, rises, r0;
    int error_cnt = 0;
    int num_checks = 0;
    logic rd_pend = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] mask, rv;

    tbpo_timer DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .bus_req(bus_req), .rdata(rdata),
        .event_pin(event_pin), .pin(pin), .irq_out(irq_out));
    tbpo_load load (.clk_sys(clk_sys), .pin(pin), .hi_w(hi_w), .lo_w(lo_w), .rises(rises));

    always #5 clk_sys = ~clk_sys;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one strobe cycle; the leading edge keeps two accesses from sharing a time step
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        if (!w) exp_q.push_back(d);
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: d};
    endtask : acc

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle

    task automatic wait_rises(input int n);
        int target;
        target = rises + n;
        for (int i = 0; i < 4000 && rises < target; i++) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : wait_rises

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim

    // read data stands only in the cycle after the strobe, so it is taken mid-cycle there
    always @(posedge clk_sys) rd_pend <= bus_req.rd;
    always @(negedge clk_sys) begin
        if (rd_pend === 1'b1) chk(16'(rdata), 16'(exp_q.pop_front()));
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        error_cnt++;
        end_sim();
    end

    initial begin
        void'($urandom(32'hfd6383ea));
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (rv[i]) acc(1'b0, `TBPO_ADDR_MODE - 8'h30 + 8'(i), 8'h00);
        acc(1'b0, `TBPO_ADDR_RELOAD, 8'h00);
        rv = 8'($urandom) & 8'h7f;
        acc(1'b1, `TBPO_ADDR_MODE, rv);
        acc(1'b0, `TBPO_ADDR_MODE, rv);
        // every pwm modulus with a random duty, set up in the safe order
        for (int m = 0; m < 4; m++) begin
            mask = (m == 0) ? `TBPO_MASK_256 : (m == 1) ? `TBPO_MASK_64 : (m == 2) ? `TBPO_MASK_32 : `TBPO_MASK_16;
            rv = 8'(1 + $urandom % mask);
            acc(1'b1, `TBPO_ADDR_MODE, 8'h00);
            acc(1'b1, `TBPO_ADDR_IRQ, 8'h00);
            acc(1'b1, `TBPO_ADDR_COUNT, 8'h00);
            acc(1'b1, `TBPO_ADDR_RELOAD, rv);
            acc(1'b1, `TBPO_ADDR_MODE, {5'h1e, m[1:0], 1'b1});
            wait_rises(3);
            chk(16'(hi_w), {7'h00, rv, 1'b0});
            chk(16'(hi_w + lo_w), 16'((16'(mask) + 16'd1) * 16'd2));
            chk(16'(pin.takeover), 16'h1);
            acc(1'b0, `TBPO_ADDR_IRQ, 8'h02);
        end
        // buzzer with auto-reload: 16 counts of 2 cycles per half period
        acc(1'b1, `TBPO_ADDR_MODE, 8'h00);
        acc(1'b1, `TBPO_ADDR_COUNT, 8'hf0);
        acc(1'b1, `TBPO_ADDR_RELOAD, 8'hf0);
        acc(1'b1, `TBPO_ADDR_MODE, 8'hf6);
        wait_rises(3);
        chk(16'(hi_w), 16'd32);
        chk(16'(lo_w), 16'd32);
        chk(16'(pin.takeover), 16'h1);
        // stopped timer holds count and pin; a write with clock enable low is lost
        acc(1'b1, `TBPO_ADDR_MODE, 8'h76);
        acc(1'b1, `TBPO_ADDR_COUNT, 8'h55);
        // a toggle launched by the last running edge must reach the load before the snapshot
        settle(2);
        r0 = rises;
        @(posedge clk_sys);
        clk_en <= 1'b0;
        acc(1'b1, `TBPO_ADDR_COUNT, 8'haa);
        clk_en <= 1'b1;
        settle(100);
        acc(1'b0, `TBPO_ADDR_COUNT, 8'h55);
        chk(16'(rises), 16'(r0));
        // slow pwm: count and reference writes act within the cycle
        acc(1'b1, `TBPO_ADDR_MODE, 8'h00);
        acc(1'b1, `TBPO_ADDR_RELOAD, 8'h80);
        acc(1'b1, `TBPO_ADDR_COUNT, 8'h10);
        acc(1'b1, `TBPO_ADDR_MODE, 8'h81);
        settle(3);
        chk(16'(pin.value), 16'h1);
        acc(1'b1, `TBPO_ADDR_COUNT, 8'h90);
        settle(3);
        chk(16'(pin.value), 16'h0);
        acc(1'b1, `TBPO_ADDR_RELOAD, 8'hc0);
        settle(3);
        chk(16'(pin.value), 16'h1);
        // sticky flag, cleared by software, gated by the enable bit
        acc(1'b1, `TBPO_ADDR_MODE, 8'h00);
        acc(1'b0, `TBPO_ADDR_IRQ, 8'h02);
        settle(1);
        chk(16'(irq_out), 16'h0);
        acc(1'b1, `TBPO_ADDR_IRQ, 8'h01);
        acc(1'b0, `TBPO_ADDR_IRQ, 8'h01);
        settle(1);
        chk(16'(irq_out), 16'h0);
        acc(1'b1, `TBPO_ADDR_IRQ, 8'h03);
        settle(2);
        chk(16'(irq_out), 16'h1);
        // event source: the fast rate field must not count, only falling edges do
        acc(1'b1, `TBPO_ADDR_COUNT, 8'h00);
        acc(1'b1, `TBPO_ADDR_MODE, 8'hf8);
        settle(100);
        acc(1'b0, `TBPO_ADDR_COUNT, 8'h00);
        repeat (3) begin
            @(posedge clk_sys);
            event_pin <= 1'b0;
            repeat (6) @(posedge clk_sys);
            event_pin <= 1'b1;
            repeat (6) @(posedge clk_sys);
        end
        settle(8);
        acc(1'b0, `TBPO_ADDR_COUNT, 8'h03);
        // reset in mid-run: mode, count and pin fall back to their reset values
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        settle(1);
        chk(16'(pin), 16'h0);
        acc(1'b0, `TBPO_ADDR_MODE, `TBPO_RST_BYTE);
        acc(1'b0, `TBPO_ADDR_COUNT, `TBPO_RST_BYTE);
        settle(2);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
